// ===== rsbm_map.vh
/*
  Constants for the terminal status and monitor capture block: status word
  fields, mode codes, capture layout and marker values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef RSBM_MAP_VH
`define RSBM_MAP_VH
`define RSBM_SW_ADDR_LSB      11
`define RSBM_SW_MERR_BIT      10
`define RSBM_SW_INSTR_BIT     9
`define RSBM_SW_SRQ_BIT       8
`define RSBM_SW_BCAST_BIT     4
`define RSBM_SW_BUSY_BIT      3
`define RSBM_SW_SUBSYS_BIT    2
`define RSBM_SW_DYNBUS_BIT    1
`define RSBM_SW_TFLAG_BIT     0
`define RSBM_ADDR_BCAST       5'h1F
`define RSBM_SA_MODE0         5'h00
`define RSBM_SA_MODE31        5'h1F
`define RSBM_MC_DYNBUS        5'h00
`define RSBM_MC_TX_STATUS     5'h02
`define RSBM_MC_INH_TFLAG     5'h06
`define RSBM_MC_OVR_TFLAG     5'h07
`define RSBM_MC_RESET         5'h08
`define RSBM_MC_TX_LASTCMD    5'h12
`define RSBM_MC_SEL_SHUT      5'h14
`define RSBM_MC_OVR_SEL_SHUT  5'h15
`define RSBM_MC_NODATA_BASE   6'h10
`define RSBM_FILT_DEPTH_LOG2  11
`define RSBM_MARKER           16'hBEEF
`define RSBM_HDR_TRIG_BIT     8
`define RSBM_HDR_WORDS        6'h0A
`define RSBM_DATA_MAX         6'h21
`define RSBM_DEC_N_LSB        16
`define RSBM_DEC_DEFAULT      16'h0001
`define RSBM_MSTAT_RESET_BIT  19
`endif

// ===== rsbm_filter_mem.v
/*
  Filter lookup memory: one word per terminal, direction and subaddress.
  Assumes software loads it through the write port before the monitor runs;
  read data come out of a register one cycle after the read address.
*/
`timescale 1ns/1ps
module rsbm_filter_mem #(
  parameter AW = 11,
  parameter DW = 32
) (
  input  wire          ref_clk_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [DW-1:0] wr_data_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [DW-1:0] rd_data_out
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];
  always @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_q[rd_addr_in];
  end
endmodule // rsbm_filter_mem

// ===== rsbm_core.v
/*
  Terminal status word upkeep and bus monitor filter, decimation and ring
  capture. Holds the filter table inside; the control entries and capture
  ring live in an outside shared memory reached by a simple request port.
  Assumes the decoder delivers command, data and end events as one-cycle
  pulses on ref_clk_in, and that the memory port answers read_ok one or
  more cycles after a read request.
*/
// Operation
// - Status word packs address and flag bits.
// - Overlay ORs extended status when enabled.
// - Address 31 broadcast gives no status.
// - Set message error on listed faults.
// - Clear error on clean command, except queries.
// - Broadcast bit set, kept by queries only.
// - Busy returns status, suppresses data words.
// - Message event posted even while busy.
// - Busy still clears broadcast bit appropriately.
// - Illegal while busy sets error and busy.
// - Last command while busy later returned.
// - Dynamic bus bit needs grant allow.
// - Index is address, direction, subaddress.
// - Pointers reference two-word control entries.
// - Capture only if count bit enabled.
// - Terminal transfers use receive command entry.
// - Mode subaddresses use mode code mask.
// - Non-broadcast reset code clears inhibits, sets flag.
// - Decimation counter decrements and reloads.
// - Ten header words then data words.
// - Ring wraps from last to first.
// - Interrupt needs allow; capture needs go.
// - Header carries marker, bytes and trigger.
`timescale 1ns/1ps
`include "rsbm_map.vh"
module rsbm_core #(
  parameter AW = 32
) (
  input  wire          ref_clk_in,
  input  wire          reset_in,
  input  wire [4:0]    own_addr_in,
  input  wire          addr31_is_broadcast_in,
  input  wire          extra_status_overlay_in,
  input  wire          bus_grant_allow_in,
  input  wire          busy_in,
  input  wire          subsys_flag_in,
  input  wire          srq_in,
  input  wire          instr_in,
  input  wire          rev_b_in,
  input  wire [15:0]   ext_status_in,
  input  wire          cmd_valid_in,
  input  wire [15:0]   cmd_word_in,
  input  wire          cmd_legal_in,
  input  wire          cmd_rt2rt_in,
  input  wire [15:0]   cmd2_word_in,
  input  wire          data_valid_in,
  input  wire [15:0]   data_word_in,
  input  wire [15:0]   data_qual_in,
  input  wire          data_bad_in,
  input  wire          count_err_in,
  input  wire          msg_done_in,
  input  wire          monitor_go_in,
  input  wire          monitor_irq_allow_in,
  input  wire          irq_mask_ready_in,
  input  wire          trig_in,
  input  wire [AW-1:0] capture_ring_first_in,
  input  wire [AW-1:0] capture_ring_last_in,
  input  wire          filt_wr_in,
  input  wire [10:0]   filt_addr_in,
  input  wire [31:0]   filt_data_in,
  input  wire          mem_rd_ok_in,
  input  wire [31:0]   mem_rd_data_in,
  output reg           mem_rd_out,
  output reg           mem_wr_out,
  output reg  [AW-1:0] mem_addr_out,
  output reg  [31:0]   mem_wr_data_out,
  output reg  [15:0]   status_word_out,
  output reg           status_valid_out,
  output reg           data_allow_out,
  output reg  [15:0]   last_cmd_out,
  output reg           terminal_was_reset_out,
  output reg           terminal_flag_inhibit_out,
  output reg           msg_event_out,
  output reg           monitor_irq_out,
  output reg  [AW-1:0] head_ptr_out,
  output reg           capturing_out
);
  localparam S_IDLE = 3'd0;
  localparam S_FILT = 3'd1;
  localparam S_CW0  = 3'd2;
  localparam S_CW1  = 3'd3;
  localparam S_DEC  = 3'd4;
  localparam S_RUN  = 3'd5;
  localparam S_HDR  = 3'd6;

  reg          merr_q;
  reg          bcast_q;
  reg          dynbus_q;
  reg [15:0]   last_busy_cmd_q;
  reg          held_busy_q;
  reg [2:0]    st_q;
  reg [AW-1:0] ent_q;
  reg [31:0]   mask_q;
  reg [AW-1:0] base_q;
  reg [AW-1:0] wptr_q;
  reg [5:0]    dcount_q;
  reg          trig_q;
  reg          keep_q;

  wire [4:0] c_addr = cmd_word_in[15:11];
  wire       c_tx   = cmd_word_in[10];
  wire [4:0] c_sa   = cmd_word_in[9:5];
  wire [4:0] c_wc   = cmd_word_in[4:0];
  wire       c_bc   = addr31_is_broadcast_in &&
                      c_addr == `RSBM_ADDR_BCAST;
  wire       c_mine = c_addr == own_addr_in;
  wire       c_mode = c_sa == `RSBM_SA_MODE0 || c_sa == `RSBM_SA_MODE31;
  wire       c_query = c_mode && c_tx && (c_wc == `RSBM_MC_TX_STATUS ||
                       (rev_b_in && c_wc == `RSBM_MC_TX_LASTCMD));
  wire       c_err  = !cmd_legal_in;
  wire       c_keep = c_mode && c_tx && (c_wc == `RSBM_MC_TX_STATUS ||
                      c_wc == `RSBM_MC_TX_LASTCMD);

  function [4:0] mask_bit;
    input [15:0] cw;
    begin
      // Mode codes index the mask directly, so each mode code sits at the mask bit of the same number.
      if (cw[9:5] == `RSBM_SA_MODE0 || cw[9:5] == `RSBM_SA_MODE31) begin
        mask_bit = cw[4:0];
      end else begin
        mask_bit = cw[4:0];
      end
    end
  endfunction

  // Terminal-to-terminal messages filter on the receive command.
  wire [15:0] f_cmd = (cmd_rt2rt_in && cmd_word_in[10]) ?
                      cmd2_word_in : cmd_word_in;
  wire [10:0] f_idx = {f_cmd[15:11], f_cmd[10], f_cmd[9:5]};
  wire [31:0] f_ptr;
  reg  [15:0] f_cmd_q;

  rsbm_filter_mem #(.AW(`RSBM_FILT_DEPTH_LOG2), .DW(32)) u_filt (
    .ref_clk_in (ref_clk_in),
    .wr_en_in   (filt_wr_in),
    .wr_addr_in (filt_addr_in),
    .wr_data_in (filt_data_in),
    .rd_addr_in (f_idx),
    .rd_data_out(f_ptr)
  );

  // Status carries the flags as this very command leaves them.
  wire merr_n  = c_err ? 1'b1 : (c_query ? merr_q : 1'b0);
  wire bcast_n = c_bc ? !busy_in : (c_keep ? bcast_q : 1'b0);
  wire dyn_n   = (c_mode && !c_err) ? ((c_wc == `RSBM_MC_DYNBUS) ?
                 bus_grant_allow_in : dynbus_q) : 1'b0;
  wire [15:0] base_sw = {own_addr_in, merr_n, instr_in, srq_in, 3'b000,
                         bcast_n, busy_in, subsys_flag_in, dyn_n,
                         1'b0};
  wire [AW-1:0] wnext = (wptr_q == capture_ring_last_in) ?
                        capture_ring_first_in : wptr_q + 1'b1;
  wire [AW-1:0] skip_raw = wptr_q + `RSBM_HDR_WORDS;
  wire [AW-1:0] skip_ptr = (skip_raw > capture_ring_last_in) ?
                           skip_raw - capture_ring_last_in - 1'b1 +
                           capture_ring_first_in : skip_raw;

  // Terminal status upkeep.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      merr_q <= 1'b0;
      bcast_q <= 1'b0;
      dynbus_q <= 1'b0;
      last_busy_cmd_q <= 16'h0000;
      held_busy_q <= 1'b0;
      status_word_out <= 16'h0000;
      status_valid_out <= 1'b0;
      data_allow_out <= 1'b0;
      last_cmd_out <= 16'h0000;
      terminal_was_reset_out <= 1'b0;
      terminal_flag_inhibit_out <= 1'b0;
      msg_event_out <= 1'b0;
    end else begin
      status_valid_out <= 1'b0;
      msg_event_out <= msg_done_in && (c_mine || c_bc);
      if (cmd_valid_in && (c_mine || c_bc)) begin
        terminal_was_reset_out <= 1'b0;
        merr_q <= merr_n;
        bcast_q <= bcast_n;
        if (busy_in) begin
          last_busy_cmd_q <= cmd_word_in;
          held_busy_q <= 1'b1;
        end
        if (c_mode && c_wc == `RSBM_MC_TX_LASTCMD && !busy_in) begin
          last_cmd_out <= held_busy_q ? last_busy_cmd_q
                                      : cmd_word_in;
          held_busy_q <= 1'b0;
        end else if (!busy_in) begin
          last_cmd_out <= cmd_word_in;
        end
        if (c_mode && !c_err) begin
          case (c_wc)
            `RSBM_MC_DYNBUS: dynbus_q <= bus_grant_allow_in;
            `RSBM_MC_INH_TFLAG: terminal_flag_inhibit_out <= 1'b1;
            `RSBM_MC_OVR_TFLAG: terminal_flag_inhibit_out <= 1'b0;
            `RSBM_MC_RESET: begin
              if (!c_bc) begin
                terminal_was_reset_out <= 1'b1;
                terminal_flag_inhibit_out <= 1'b0;
              end
            end
            // Selected shutdown codes are answered but change nothing.
            default: dynbus_q <= dynbus_q;
          endcase
        end else begin
          dynbus_q <= 1'b0;
        end
        // Data words are suppressed while the subsystem is busy.
        data_allow_out <= !busy_in && !c_err;
        if (!c_bc) begin
          status_valid_out <= 1'b1;
          status_word_out <= extra_status_overlay_in ?
                             (base_sw | ext_status_in) : base_sw;
        end
      end else if (msg_done_in) begin
        data_allow_out <= 1'b0;
      end
      // A word error beside a clean command still leaves the flag set.
      if (data_valid_in && (data_bad_in || count_err_in)) begin
        merr_q <= 1'b1;
      end
    end
  end

  // Monitor: filter lookup, control entry fetch, decimation, capture.
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= S_IDLE;
      ent_q <= {AW{1'b0}};
      mask_q <= 32'h0000_0000;
      base_q <= {AW{1'b0}};
      wptr_q <= {AW{1'b0}};
      dcount_q <= 6'h00;
      trig_q <= 1'b0;
      keep_q <= 1'b0;
      f_cmd_q <= 16'h0000;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_addr_out <= {AW{1'b0}};
      mem_wr_data_out <= 32'h0000_0000;
      monitor_irq_out <= 1'b0;
      head_ptr_out <= {AW{1'b0}};
      capturing_out <= 1'b0;
    end else begin
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      monitor_irq_out <= 1'b0;
      if (trig_in) begin
        trig_q <= 1'b1;
      end
      case (st_q)
        S_IDLE: begin
          capturing_out <= 1'b0;
          if (!monitor_go_in) begin
            wptr_q <= capture_ring_first_in;
          end
          if (cmd_valid_in && monitor_go_in) begin
            f_cmd_q <= f_cmd;
            st_q <= S_FILT;
          end
        end
        S_FILT: begin
          ent_q <= f_ptr[AW-1:0];
          mem_rd_out <= 1'b1;
          mem_addr_out <= f_ptr[AW-1:0];
          st_q <= S_CW0;
        end
        S_CW0: begin
          if (mem_rd_ok_in) begin
            mask_q <= mem_rd_data_in;
            mem_rd_out <= 1'b1;
            mem_addr_out <= ent_q + 1'b1;
            st_q <= S_CW1;
          end
        end
        S_CW1: begin
          if (mem_rd_ok_in) begin
            keep_q <= mask_q[mask_bit(f_cmd_q)] &&
                      mem_rd_data_in[15:0] == 16'h0001;
            mem_wr_out <= 1'b1;
            mem_addr_out <= ent_q + 1'b1;
            mem_wr_data_out <= (mem_rd_data_in[15:0] <= 16'h0001) ?
              {mem_rd_data_in[31:16], mem_rd_data_in[31:16]} :
              {mem_rd_data_in[31:16],
               mem_rd_data_in[15:0] - 16'h0001};
            st_q <= S_DEC;
          end
        end
        S_DEC: begin
          if (keep_q) begin
            base_q <= wptr_q;
            wptr_q <= wptr_q;
            dcount_q <= 6'h00;
            capturing_out <= 1'b1;
            st_q <= S_RUN;
          end else begin
            st_q <= S_IDLE;
          end
        end
        S_RUN: begin
          // Header words beyond the first are never written; data start ten words past the base.
          if (data_valid_in && dcount_q < `RSBM_DATA_MAX) begin
            mem_wr_out <= 1'b1;
            mem_addr_out <= (dcount_q == 6'h00) ? skip_ptr :
                            wptr_q;
            mem_wr_data_out <= {data_qual_in, data_word_in};
            wptr_q <= (dcount_q != 6'h00) ? wnext :
              (skip_ptr == capture_ring_last_in) ? capture_ring_first_in :
              skip_ptr + 1'b1;
            dcount_q <= dcount_q + 6'h01;
          end
          if (msg_done_in) begin
            st_q <= S_HDR;
          end
        end
        S_HDR: begin
          mem_wr_out <= 1'b1;
          mem_addr_out <= base_q;
          mem_wr_data_out <= {`RSBM_MARKER, 7'h00, trig_q,
            {dcount_q + `RSBM_HDR_WORDS, 2'b00}};
          // A trigger landing with the header belongs to the next message.
          trig_q <= trig_in;
          head_ptr_out <= base_q;
          if (dcount_q == 6'h00) begin
            wptr_q <= skip_ptr;
          end
          monitor_irq_out <= monitor_irq_allow_in &&
                             irq_mask_ready_in;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // rsbm_core

// ===== rsbm_core_sva.sv
/* Checker for rsbm_core status answers and capture ring upkeep.
   Assumes it is bound to rsbm_core and sees only its ports. */
`timescale 1ns/1ps
module rsbm_core_chk #(
  parameter AW = 32
) (
  input wire logic          ref_clk_in,
  input wire logic          reset_in,
  input wire logic [4:0]    own_addr_in,
  input wire logic          addr31_is_broadcast_in,
  input wire logic          bus_grant_allow_in,
  input wire logic          busy_in,
  input wire logic          cmd_valid_in,
  input wire logic [15:0]   cmd_word_in,
  input wire logic          cmd_legal_in,
  input wire logic          monitor_irq_allow_in,
  input wire logic          irq_mask_ready_in,
  input wire logic [AW-1:0] capture_ring_first_in,
  input wire logic [AW-1:0] capture_ring_last_in,
  input wire logic [15:0]   status_word_out,
  input wire logic          status_valid_out,
  input wire logic          monitor_irq_out,
  input wire logic [AW-1:0] head_ptr_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic mine;
  assign mine = cmd_valid_in && cmd_word_in[15:11] == own_addr_in &&
                !(addr31_is_broadcast_in && own_addr_in == 5'h1F);
  sequence s_reply(bit b);
    ##[1:2] (status_valid_out && b);
  endsequence
  a_status_answer: assert property (mine |-> s_reply(1'b1))
    else $error("no status after command");
  a_bcast_silent: assert property (cmd_valid_in && addr31_is_broadcast_in &&
    cmd_word_in[15:11] == 5'h1F |=> !status_valid_out [*2])
    else $error("status for broadcast");
  a_addr_field: assert property (status_valid_out |->
    status_word_out[15:11] == own_addr_in)
    else $error("address field wrong");
  a_busy_flag: assert property (mine && busy_in |->
    ##[1:2] (status_valid_out && status_word_out[3]))
    else $error("busy not reported");
  a_illegal_err: assert property (mine && !cmd_legal_in |->
    ##[1:2] (status_valid_out && status_word_out[10]))
    else $error("error bit missing");
  a_dynbus_gate: assert property (status_valid_out && !bus_grant_allow_in
    |-> !status_word_out[1])
    else $error("bus grant bit without allow");
  a_irq_gate: assert property (monitor_irq_out |->
    monitor_irq_allow_in && irq_mask_ready_in)
    else $error("monitor interrupt not allowed");
  a_head_ring: assert property ($changed(head_ptr_out) |->
    head_ptr_out >= capture_ring_first_in &&
    head_ptr_out <= capture_ring_last_in)
    else $error("head outside ring");
endmodule // rsbm_core_chk

bind rsbm_core rsbm_core_chk #(.AW(AW)) u_chk (.*);

// ===== rsbm_mem_model.sv
/* Shared memory behind the capture port.
   Assumes one-cycle strobes; answers reads after one or three clocks. */
`timescale 1ns/1ps
module rsbm_mem_model (
  input  wire logic        ref_clk_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic        slow_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output logic             ok_out,
  output logic [31:0]      rdata_out
);
  logic [31:0] mem [0:511];
  logic [8:0]  rd_addr;
  logic [1:0]  wait_cnt;
  initial begin
    ok_out = 1'h0;
    rdata_out = 32'h0;
    wait_cnt = 2'h0;
  end
  // Idle data lines flip each clock so a stale word never looks fresh.
  always @(posedge ref_clk_in) begin
    ok_out <= 1'h0;
    rdata_out <= ~rdata_out;
    if (wr_in)
      mem[addr_in[8:0]] <= wdata_in;
    if (rd_in) begin
      rd_addr <= addr_in[8:0];
      wait_cnt <= slow_in ? 2'h3 : 2'h1;
    end else if (wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
      if (wait_cnt == 2'h1) begin
        ok_out <= 1'h1;
        rdata_out <= mem[rd_addr];
      end
    end
  end
endmodule // rsbm_mem_model

// ===== testbench.sv
/* Self-checking bench for rsbm_core.
   Assumes rsbm_mem_model stands on the shared memory port. */
`timescale 1ns/1ps
module testbench;
  logic ref_clk_in, reset_in, busy_in, subsys_flag_in, srq_in, instr_in;
  logic rev_b_in, addr31_is_broadcast_in, cmd_valid_in, cmd_legal_in;
  logic extra_status_overlay_in, bus_grant_allow_in, cmd_rt2rt_in;
  logic data_valid_in, data_bad_in, count_err_in, msg_done_in, trig_in;
  logic monitor_go_in, monitor_irq_allow_in, irq_mask_ready_in, slow;
  logic filt_wr_in, mem_rd_ok_in, mem_rd_out, mem_wr_out, sv;
  logic status_valid_out, data_allow_out, terminal_was_reset_out;
  logic terminal_flag_inhibit_out, msg_event_out, monitor_irq_out;
  logic capturing_out;
  logic [4:0] own_addr_in;
  logic [10:0] filt_addr_in;
  logic [15:0] ext_status_in, cmd_word_in, cmd2_word_in, data_word_in;
  logic [15:0] data_qual_in, status_word_out, last_cmd_out, sw;
  logic [31:0] capture_ring_first_in, capture_ring_last_in, filt_data_in;
  logic [31:0] mem_rd_data_in, mem_addr_out, mem_wr_data_out, head_ptr_out;
  int fail_count = 0, samples_checked = 0, irqs = 0;

  rsbm_core DUT (.*);
  rsbm_mem_model m (.ref_clk_in(ref_clk_in), .rd_in(mem_rd_out),
    .wr_in(mem_wr_out), .slow_in(slow), .addr_in(mem_addr_out),
    .wdata_in(mem_wr_data_out), .ok_out(mem_rd_ok_in),
    .rdata_out(mem_rd_data_in));

  initial begin
    ref_clk_in = 1'h0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in)
    if (monitor_irq_out === 1'h1) irqs++;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function logic [15:0] cw(input logic [4:0] a, input logic t,
                           input logic [4:0] s, input logic [4:0] w);
    return {a, t, s, w};
  endfunction
  task send(input logic [15:0] w, input logic lg);
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'h1;
    cmd_word_in <= w;
    cmd_legal_in <= lg;
    @(posedge ref_clk_in);
    cmd_valid_in <= 1'h0;
    sv = 1'h0;
    repeat (3) begin
      #1;
      if (status_valid_out === 1'h1) begin
        sv = 1'h1;
        sw = status_word_out;
      end
      @(posedge ref_clk_in);
    end
  endtask
  task msg(input logic [4:0] wc);
    int i;
    send(cmd_rt2rt_in ? cw(5'h07, 1'h1, 5'h02, wc) :
         cw(5'h03, 1'h0, 5'h01, wc), 1'h1);
    // Look after the edge so the flag is seen once it has settled.
    for (i = 0; i < 30 && capturing_out !== 1'h1; i++) begin
      @(posedge ref_clk_in);
      #1;
    end
    @(posedge ref_clk_in);
    for (i = 0; i < wc; i++) begin
      data_valid_in <= 1'h1;
      data_word_in <= 16'hA000 + 16'(i);
      data_qual_in <= 16'h0010;
      @(posedge ref_clk_in);
    end
    data_valid_in <= 1'h0;
    msg_done_in <= 1'h1;
    @(posedge ref_clk_in);
    msg_done_in <= 1'h0;
    repeat (10) @(posedge ref_clk_in);
  endtask

  task t_status;
    srq_in <= 1'h1;
    instr_in <= 1'h1;
    subsys_flag_in <= 1'h1;
    send(cw(5'h05, 1'h1, 5'h01, 5'h04), 1'h1);
    chk(sv, 1'h1);
    chk(sw, 16'h2B04);
    extra_status_overlay_in <= 1'h1;
    ext_status_in <= 16'h0020;
    send(cw(5'h05, 1'h1, 5'h01, 5'h04), 1'h1);
    chk(sw, 16'h2B24);
    extra_status_overlay_in <= 1'h0;
    $display("status test done");
  endtask
  task t_merr;
    busy_in <= 1'h1;
    send(cw(5'h05, 1'h0, 5'h01, 5'h02), 1'h0);
    chk(sw[10], 1'h1);
    chk(sw[3], 1'h1);
    chk(data_allow_out, 1'h0);
    msg_done_in <= 1'h1;
    @(posedge ref_clk_in);
    msg_done_in <= 1'h0;
    #1;
    chk(msg_event_out, 1'h1);
    @(posedge ref_clk_in);
    busy_in <= 1'h0;
    send(cw(5'h05, 1'h1, 5'h00, 5'h02), 1'h1);
    chk(sw[10], 1'h1);
    chk(data_allow_out, 1'h1);
    rev_b_in <= 1'h1;
    send(cw(5'h05, 1'h1, 5'h00, 5'h12), 1'h1);
    chk(sw[10], 1'h1);
    rev_b_in <= 1'h0;
    busy_in <= 1'h1;
    send(cw(5'h05, 1'h1, 5'h01, 5'h03), 1'h1);
    chk(sw[10], 1'h0);
    busy_in <= 1'h0;
    send(cw(5'h05, 1'h1, 5'h00, 5'h12), 1'h1);
    chk(last_cmd_out, 16'h2C23);
    $display("error test done");
  endtask
  task t_bcast;
    addr31_is_broadcast_in <= 1'h1;
    send(cw(5'h1F, 1'h0, 5'h01, 5'h02), 1'h1);
    chk(sv, 1'h0);
    send(cw(5'h05, 1'h1, 5'h00, 5'h02), 1'h1);
    chk(sw[4], 1'h1);
    send(cw(5'h05, 1'h1, 5'h00, 5'h12), 1'h1);
    chk(sw[4], 1'h1);
    send(cw(5'h05, 1'h1, 5'h01, 5'h02), 1'h1);
    chk(sw[4], 1'h0);
    send(cw(5'h1F, 1'h0, 5'h01, 5'h02), 1'h1);
    busy_in <= 1'h1;
    send(cw(5'h1F, 1'h0, 5'h01, 5'h02), 1'h1);
    send(cw(5'h05, 1'h1, 5'h00, 5'h02), 1'h1);
    chk(sw[4], 1'h0);
    busy_in <= 1'h0;
    send(cw(5'h05, 1'h1, 5'h00, 5'h06), 1'h1);
    chk(terminal_flag_inhibit_out, 1'h1);
    send(cw(5'h05, 1'h1, 5'h00, 5'h08), 1'h1);
    chk(terminal_was_reset_out, 1'h1);
    chk(terminal_flag_inhibit_out, 1'h0);
    bus_grant_allow_in <= 1'h1;
    send(cw(5'h05, 1'h1, 5'h00, 5'h00), 1'h1);
    chk(sw[1], 1'h1);
    bus_grant_allow_in <= 1'h0;
    send(cw(5'h05, 1'h1, 5'h00, 5'h00), 1'h1);
    chk(sw[1], 1'h0);
    $display("broadcast test done");
  endtask
  task t_capture;
    monitor_go_in <= 1'h1;
    trig_in <= 1'h1;
    @(posedge ref_clk_in);
    trig_in <= 1'h0;
    msg(5'h02);
    chk(m.mem[1], 32'h0002_0001);
    msg(5'h02);
    chk(m.mem[1], 32'h0002_0002);
    chk(m.mem[9'h100], 32'hBEEF_0130);
    chk(m.mem[9'h10B], 32'h0010_A001);
    msg(5'h03);
    chk(head_ptr_out, 32'h0000_0100);
    slow <= 1'h1;
    monitor_irq_allow_in <= 1'h1;
    irq_mask_ready_in <= 1'h1;
    msg(5'h01);
    msg(5'h01);
    chk(m.mem[9'h10C], 32'hBEEF_002C);
    chk(m.mem[9'h109], 32'h0010_A000);
    chk(head_ptr_out, 32'h0000_010C);
    chk(irqs, 32'h1);
    cmd_rt2rt_in <= 1'h1;
    cmd2_word_in <= cw(5'h03, 1'h0, 5'h01, 5'h02);
    @(posedge ref_clk_in);
    msg(5'h02);
    cmd_rt2rt_in <= 1'h0;
    chk(head_ptr_out, 32'h0000_010A);
    chk(irqs, 32'h2);
    $display("capture test done");
  endtask

  initial begin
    reset_in = 1'h1;
    {busy_in, subsys_flag_in, srq_in, instr_in, rev_b_in, cmd_valid_in,
     addr31_is_broadcast_in, cmd_legal_in, extra_status_overlay_in,
     bus_grant_allow_in, cmd_rt2rt_in, data_valid_in, data_bad_in,
     count_err_in, msg_done_in, trig_in, monitor_go_in, filt_wr_in,
     monitor_irq_allow_in, irq_mask_ready_in, slow} = '0;
    {ext_status_in, cmd_word_in, cmd2_word_in, data_word_in, data_qual_in,
     filt_addr_in} = '0;
    own_addr_in = 5'h05;
    capture_ring_first_in = 32'h0000_0100;
    capture_ring_last_in = 32'h0000_010C;
    filt_data_in = 32'h0;
    m.mem[0] = 32'h0000_0006;
    m.mem[1] = 32'h0002_0002;
    repeat (20) @(posedge ref_clk_in);
    reset_in <= 1'h0;
    @(posedge ref_clk_in);
    filt_wr_in <= 1'h1;
    filt_addr_in <= 11'h061;
    @(posedge ref_clk_in);
    filt_wr_in <= 1'h0;
    t_status;
    t_merr;
    t_bcast;
    t_capture;
    finish_test;
  end
  initial begin
    #100000;
    fail_count++;
    finish_test;
  end
endmodule // testbench
